// [dv/rbk_time_model.sv]
`timescale 1ns/10ps
`default_nettype none
module rbk_time_model (
  input  wire logic               clock_in,
  input  wire logic               rst_b_in,
  input  wire logic               step_in,
  input  wire rbk_pkg::rbk_time_t next_in,
  output var rbk_pkg::rbk_time_t  time_out,
  output logic                    tick_out
);
  import rbk_pkg::*;
  // Time base: a step loads the new count and raises the flag on the same edge, one cycle after step_in, for as many cycles as step_in is held,
  // so the block sees one advance per cycle of step_in
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      time_out <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= step_in;
      if (step_in)
        time_out <= next_in;
    end
  end
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rbk_pkg::*;
  localparam int PC = 16;
  logic       clock_in, rst_b_in, wr, rd, rp, rb, rt, bo, step, tick;
  logic       irq, pin, oe, onb, busen, memen, auxen, lowv;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  rbk_time_t  tnow, nxt;
  int         err_total, checks_done;
  // Open-drain pin with its pull-up on the battery rail
  wire        pin_lvl = oe ? pin : 1'b1;

  rbk_top #(.PULSE_CYCLES(16'(PC))) DUT (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .time_in(tnow), .tick_in(tick), .vdd_ok_reset_in(rp),
    .vdd_ok_bat_in(rb), .vdd_ok_trip_in(rt), .bat_ok_reset_in(bo),
    .irq_out(irq), .irq_pin_out(pin), .irq_pin_oe_out(oe),
    .on_battery_out(onb), .bus_enable_out(busen), .mem_enable_out(memen),
    .aux_enable_out(auxen), .low_voltage_reset_out(lowv));
  rbk_time_model TM (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .step_in(step),
    .next_in(nxt), .time_out(tnow), .tick_out(tick));

  // Clock, 8 ns period
  initial
  begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock_in);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock_in);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic tk(input rbk_time_t t);
    @(posedge clock_in);
    nxt  <= t;
    step <= 1'b1;
    @(posedge clock_in);
    step <= 1'b0;
    repeat (4) @(posedge clock_in);
    #1;
  endtask

  // Width of the next pin pulse; a missing or endless pulse is a mismatch
  task automatic pulse_len(output int n);
    n = 0;
    while (oe !== 1'b1 && n < 10)
    begin
      @(posedge clock_in);
      #1 n++;
    end
    if (n == 10)
    begin
      chk(8'h00, 8'h01);
      wrap_up();
    end
    for (n = 0; oe === 1'b1 && n < 200; n++)
    begin
      @(posedge clock_in);
      #1;
    end
    if (n >= 200)
    begin
      chk(8'(n), 8'(PC));
      wrap_up();
    end
  endtask

  function automatic logic [7:0] exp_pw(logic [1:0] m, logic [3:0] s);
    logic r, b, t, q, on, bus, aux;
    {r, b, t, q} = s;
    on  = m[0] ? !b : !t;
    bus = !m[0] ? r & t : (m[1] ? r & b : r & (b | q));
    aux = m[0] | t;
    return {3'h0, !r, on, bus, bus, aux};
  endfunction

  // Defaults after power-up and the unmapped hole
  task automatic sc_reset();
    logic [7:0] v;
    rreg(4'h0, v);
    chk(v, 8'h00);
    wreg(4'h5, 8'hff);
    rreg(4'h5, v);
    chk(v, 8'h00);
  endtask

  // Every mode against every supply combination
  task automatic sc_supply();
    logic [7:0] v;
    for (int m = 0; m < 4; m++)
    begin
      wreg(4'h0, 8'(m));
      for (int s = 0; s < 16; s++)
      begin
        @(posedge clock_in);
        {rp, rb, rt, bo} <= 4'(s);
        repeat (3) @(posedge clock_in);
        // Host bus pulled to the battery rail, so reads go on in backup
        rreg(4'h4, v);
        chk(v, exp_pw(2'(m), 4'(s)));
        chk({3'h0, lowv, onb, busen, memen, auxen}, v);
      end
    end
    wreg(4'h0, 8'h00);
    rreg(4'h2, v);
    chk(v, 8'h02);
  endtask

  // One-shot alarm on month, date, hour and minute, held until status is read
  task automatic sc_single();
    logic [7:0] v;
    rbk_time_t  hit;
    hit = {7'h00, 7'h01, 7'h01, 7'h11, 7'h30, 7'h00};
    wreg(4'h9, 8'hb0);
    wreg(4'ha, 8'h91);
    wreg(4'hb, 8'h81);
    wreg(4'hc, 8'h81);
    wreg(4'h3, 8'h01);
    wreg(4'h1, 8'h00);
    tk(hit);
    chk({7'h0, pin_lvl}, 8'h01);
    wreg(4'h1, 8'h20);
    tk({7'h00, 7'h01, 7'h01, 7'h11, 7'h29, 7'h00});
    chk({7'h0, pin_lvl}, 8'h01);
    tk(hit);
    chk({6'h0, pin_lvl, irq}, 8'h01);
    tk(hit);
    rreg(4'h2, v);
    chk(v, 8'h01);
    repeat (2) @(posedge clock_in);
    #1 chk({6'h0, pin_lvl, irq}, 8'h02);
    for (int f = 8; f < 14; f++)
      wreg(4'(f), 8'h00);
    tk(hit);
    rreg(4'h2, v);
    chk({6'h0, v[0], pin_lvl}, 8'h01);
  endtask

  // Seconds-only alarm at 30 in repeat mode, masked off the level line
  task automatic sc_repeat();
    int         n;
    logic [7:0] v;
    wreg(4'h3, 8'h00);
    wreg(4'h8, 8'hb0);
    wreg(4'h1, 8'ha0);
    for (int mn = 5; mn < 7; mn++)
    begin
      @(posedge clock_in);
      nxt  <= {35'h0, 7'(mn), 7'h30};
      step <= 1'b1;
      @(posedge clock_in);
      step <= 1'b0;
      pulse_len(n);
      chk(8'(n), 8'(PC));
      chk({7'h0, irq}, 8'h00);
      rreg(4'h2, v);
      chk(v, 8'h01);
    end
    tk({35'h0, 7'h06, 7'h31});
    chk({7'h0, pin_lvl}, 8'h01);
  endtask

  initial
  begin
    err_total = 0;
    checks_done = 0;
    {rst_b_in, wr, rd, step} = 4'h0;
    {rp, rb, rt, bo} = 4'hf;
    addr = 4'h0;
    wdata = 8'h00;
    nxt = '0;
    repeat (4) @(posedge clock_in);
    rst_b_in <= 1'b1;
    sc_reset();
    sc_supply();
    sc_single();
    sc_repeat();
    wrap_up();
  end
endmodule
`default_nettype wire

// [src/rbk_alarm_cmp.sv]
`timescale 1ns/10ps
`default_nettype none
`include "rbk_params.svh"
module rbk_alarm_cmp (
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  rbk_if.cmp        cm
);
  import rbk_pkg::*;
  rbk_cmp_t   state_reg;
  rbk_cmp_t   state_next;
  logic [5:0] en_vec;
  logic [5:0] ok_vec;

  function automatic logic field_hit(input logic [7:0] a,
                                     input logic [6:0] t);
    field_hit = a[`RBK_FIELD_EN] && (a[6:0] == t);
  endfunction

  // Disabled fields are don't-care
  for (genvar i = 0; i < `RBK_NUM_FIELDS; i++)
  begin : g_field
    assign en_vec[i] = cm.alarm[i][`RBK_FIELD_EN];
    assign ok_vec[i] = !en_vec[i] || field_hit(cm.alarm[i], cm.now[i]);
  end

  // Checked only on a time update, so one match per update at most
  always_comb
  begin
    state_next = '0;
    state_next.match = cm.tick && (|en_vec) && (&ok_vec);
  end

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign cm.match = state_reg.match;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  a_none_enabled: assert property (cm.tick && (en_vec == 6'h00)
    |=> !cm.match)
    else $error("match with no field enabled");
  a_field_value: assert property (cm.tick && (cm.alarm[0] == 8'hb0)
    && (cm.alarm[5:1] == '0) && (cm.now[0] == 7'h30)
    |=> cm.match)
    else $error("seconds field match missed");
  a_match_cause: assert property (cm.match |-> $past(cm.tick))
    else $error("match without time update");
endmodule
`default_nettype wire

// [src/rbk_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface rbk_if;
  import rbk_pkg::*;
  rbk_mode_t  mode;
  logic       vdd_ok_reset;
  logic       vdd_ok_bat;
  logic       vdd_ok_trip;
  logic       bat_ok_reset;
  rbk_power_t power;
  rbk_alarm_t alarm;
  rbk_time_t  now;
  logic       tick;
  logic       match;
  modport ctl (output mode, vdd_ok_reset, vdd_ok_bat, vdd_ok_trip,
               bat_ok_reset, alarm, now, tick, input power, match);
  modport pwr (input mode, vdd_ok_reset, vdd_ok_bat, vdd_ok_trip,
               bat_ok_reset, output power);
  modport cmp (input alarm, now, tick, output match);
endinterface
`default_nettype wire

// [src/rbk_params.svh]
`ifndef RBK_PARAMS_SVH
`define RBK_PARAMS_SVH
`define RBK_ADDR_W     4
`define RBK_DATA_W     8
`define RBK_OFF_BACKUP 4'h0
`define RBK_OFF_INTCTL 4'h1
`define RBK_OFF_STATUS 4'h2
`define RBK_OFF_MASK   4'h3
`define RBK_OFF_POWER  4'h4
`define RBK_OFF_ALARM0 4'h8
`define RBK_NUM_FIELDS 6
`define RBK_BIT_SWSEL  0
`define RBK_BIT_INHIB  1
`define RBK_BIT_ALARM0_EN 5
`define RBK_BIT_REPEAT 7
`define RBK_FIELD_EN   7
`define RBK_EV_ALARM   0
`define RBK_EV_BACKUP  1
`define RBK_CLK_NS     8
`define RBK_PULSE_NS   1000
`define RBK_PULSE_CYC  (`RBK_PULSE_NS / `RBK_CLK_NS)
`endif

// [src/rbk_pkg.sv]
package rbk_pkg;
  // {inhibit, switch-select}
  typedef enum logic [1:0] {
    RBK_MODE_A = 2'b00,
    RBK_MODE_B = 2'b01,
    RBK_MODE_C = 2'b10,
    RBK_MODE_D = 2'b11
  } rbk_mode_t;
  // Index 0 sec, 1 min, 2 hour, 3 date, 4 month, 5 weekday
  typedef logic [5:0][6:0] rbk_time_t;
  typedef logic [5:0][7:0] rbk_alarm_t;
  typedef struct packed {
    logic on_battery;
    logic bus_en;
    logic mem_en;
    logic aux_en;
  } rbk_power_t;
  typedef struct packed {
    logic match;
  } rbk_cmp_t;
  typedef struct packed {
    logic       swsel;
    logic       inhib;
    logic       repeat_mode;
    logic       alarm0_enable;
    rbk_alarm_t alarm;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] rdata;
    logic       irq;
    logic       pin_oe;
    logic [15:0] pulse_cnt;
    rbk_power_t power;
    logic       lowv_reset;
    logic       was_batt;
  } rbk_top_t;
endpackage

// [src/rbk_power_ctl.sv]
`timescale 1ns/10ps
`default_nettype none
module rbk_power_ctl (
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  rbk_if.pwr        pw
);
  import rbk_pkg::*;
  rbk_power_t state_reg;
  rbk_power_t state_next;

  // Supply steering per backup mode
  always_comb
  begin
    state_next = '0;
    unique case (pw.mode)
      RBK_MODE_A, RBK_MODE_C:
      begin
        state_next.on_battery = !pw.vdd_ok_trip;
        state_next.bus_en = pw.vdd_ok_reset && pw.vdd_ok_trip;
        state_next.mem_en = pw.vdd_ok_reset && pw.vdd_ok_trip;
        state_next.aux_en = pw.vdd_ok_trip;
      end
      RBK_MODE_B:
      begin
        state_next.on_battery = !pw.vdd_ok_bat;
        state_next.bus_en = pw.vdd_ok_bat || pw.bat_ok_reset;
        state_next.mem_en = pw.vdd_ok_bat || pw.bat_ok_reset;
        state_next.aux_en = 1'b1;
      end
      RBK_MODE_D:
      begin
        state_next.on_battery = !pw.vdd_ok_bat;
        state_next.bus_en = pw.vdd_ok_bat;
        state_next.mem_en = pw.vdd_ok_bat;
        state_next.aux_en = 1'b1;
      end
    endcase
    // Undervoltage wins over any programmed mode
    if (!pw.vdd_ok_reset)
    begin
      state_next.bus_en = 1'b0;
      state_next.mem_en = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign pw.power = state_reg;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  a_std_no_bus: assert property ((pw.mode == RBK_MODE_A) && !pw.vdd_ok_trip
    |=> pw.power.on_battery && !pw.power.bus_en)
    else $error("mode A bus active on battery");
  a_c_like_a: assert property ((pw.mode == RBK_MODE_C) && !pw.vdd_ok_trip
    |=> !pw.power.bus_en && !pw.power.aux_en)
    else $error("mode C differs from mode A");
  a_b_bus_batt: assert property ((pw.mode == RBK_MODE_B) && !pw.vdd_ok_bat
    && pw.vdd_ok_reset && pw.bat_ok_reset
    |=> pw.power.bus_en && pw.power.mem_en)
    else $error("mode B bus lost on good battery");
  a_d_no_mem: assert property ((pw.mode == RBK_MODE_D) && !pw.vdd_ok_bat
    |=> !pw.power.bus_en && !pw.power.mem_en)
    else $error("mode D access on battery");
  a_std_aux_off: assert property (!pw.mode[0] && !pw.vdd_ok_trip
    |=> !pw.power.aux_en)
    else $error("standard mode functions left on");
  a_legacy_aux: assert property (pw.mode[0] |=> pw.power.aux_en)
    else $error("legacy mode functions dropped");
endmodule
`default_nettype wire

// [src/rbk_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "rbk_params.svh"
module rbk_top #(
  parameter logic [15:0] PULSE_CYCLES = 16'(`RBK_PULSE_CYC)
) (
  input  wire logic              clock_in,
  input  wire logic              rst_b_in,
  input  wire logic [3:0]        addr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic [7:0]             rdata_out,
  input  wire rbk_pkg::rbk_time_t time_in,
  input  wire logic              tick_in,
  input  wire logic              vdd_ok_reset_in,
  input  wire logic              vdd_ok_bat_in,
  input  wire logic              vdd_ok_trip_in,
  input  wire logic              bat_ok_reset_in,
  output logic                   irq_out,
  output logic                   irq_pin_out,
  output logic                   irq_pin_oe_out,
  output logic                   on_battery_out,
  output logic                   bus_enable_out,
  output logic                   mem_enable_out,
  output logic                   aux_enable_out,
  output logic                   low_voltage_reset_out
);
  import rbk_pkg::*;
  rbk_top_t   s_reg;
  rbk_top_t   s_next;
  logic [1:0] ev;
  logic       rd_status;
  rbk_if      link ();

  // Control bits and time into the leaf blocks
  assign link.mode = rbk_mode_t'({s_reg.inhib, s_reg.swsel});
  assign link.vdd_ok_reset = vdd_ok_reset_in;
  assign link.vdd_ok_bat = vdd_ok_bat_in;
  assign link.vdd_ok_trip = vdd_ok_trip_in;
  assign link.bat_ok_reset = bat_ok_reset_in;
  assign link.alarm = s_reg.alarm;
  assign link.now = time_in;
  assign link.tick = tick_in;

  rbk_power_ctl u_power (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .pw       (link.pwr)
  );

  rbk_alarm_cmp u_alarm (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .cm       (link.cmp)
  );

  assign rd_status = rd_in && (addr_in == `RBK_OFF_STATUS);

  // Events into sticky status
  always_comb
  begin
    ev = 2'b00;
    ev[`RBK_EV_ALARM] = link.match && s_reg.alarm0_enable;
    ev[`RBK_EV_BACKUP] = link.power.on_battery && !s_reg.was_batt;
  end

  // Register file, status, irq pin
  always_comb
  begin
    s_next = s_reg;
    s_next.rdata = 8'h00;
    s_next.was_batt = link.power.on_battery;
    s_next.power = link.power;
    s_next.lowv_reset = !vdd_ok_reset_in;
    if (wr_in)
    begin
      case (addr_in)
        `RBK_OFF_BACKUP:
        begin
          s_next.swsel = wdata_in[`RBK_BIT_SWSEL];
          s_next.inhib = wdata_in[`RBK_BIT_INHIB];
        end
        `RBK_OFF_INTCTL:
        begin
          s_next.repeat_mode = wdata_in[`RBK_BIT_REPEAT];
          s_next.alarm0_enable = wdata_in[`RBK_BIT_ALARM0_EN];
        end
        `RBK_OFF_MASK: s_next.mask = wdata_in[1:0];
        default: ;
      endcase
      for (int i = 0; i < `RBK_NUM_FIELDS; i++)
        if (addr_in == (`RBK_OFF_ALARM0 + 4'(i)))
          s_next.alarm[i] = wdata_in;
    end
    if (rd_in)
    begin
      case (addr_in)
        `RBK_OFF_BACKUP:
        begin
          s_next.rdata[`RBK_BIT_SWSEL] = s_reg.swsel;
          s_next.rdata[`RBK_BIT_INHIB] = s_reg.inhib;
        end
        `RBK_OFF_INTCTL:
        begin
          s_next.rdata[`RBK_BIT_REPEAT] = s_reg.repeat_mode;
          s_next.rdata[`RBK_BIT_ALARM0_EN] = s_reg.alarm0_enable;
        end
        `RBK_OFF_STATUS: s_next.rdata[1:0] = s_reg.status;
        `RBK_OFF_MASK:   s_next.rdata[1:0] = s_reg.mask;
        `RBK_OFF_POWER:  s_next.rdata[4:0] = {s_reg.lowv_reset, s_reg.power};
        default: ;
      endcase
      for (int i = 0; i < `RBK_NUM_FIELDS; i++)
        if (addr_in == (`RBK_OFF_ALARM0 + 4'(i)))
          s_next.rdata = s_reg.alarm[i];
    end
    // Clear on read, but a same-cycle event survives
    s_next.status = (rd_status ? 2'b00 : s_reg.status) | ev;
    s_next.irq = |(s_next.status & s_next.mask);
    // Single mode holds the pin until the flag is read away
    // New mode takes effect with the write, so in single mode the pin follows the flag from that same cycle
    if (!s_next.repeat_mode)
    begin
      s_next.pulse_cnt = 16'h0000;
      s_next.pin_oe = s_next.status[`RBK_EV_ALARM];
    end
    else
    begin
      // Each match with alarm0_enable set restarts a fixed-width low pulse
      if (ev[`RBK_EV_ALARM])
        s_next.pulse_cnt = PULSE_CYCLES;
      else if (s_reg.pulse_cnt != 16'h0000)
        s_next.pulse_cnt = s_reg.pulse_cnt - 16'h0001;
      s_next.pin_oe = (s_next.pulse_cnt != 16'h0000);
    end
  end

  // Reset picks standard mode, alarm off
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // Open-drain pin only ever pulls low; board pull-up sets its rail
  assign irq_pin_out = 1'b0;
  assign rdata_out = s_reg.rdata;
  assign irq_out = s_reg.irq;
  assign irq_pin_oe_out = s_reg.pin_oe;
  assign on_battery_out = s_reg.power.on_battery;
  assign bus_enable_out = s_reg.power.bus_en;
  assign mem_enable_out = s_reg.power.mem_en;
  assign aux_enable_out = s_reg.power.aux_en;
  assign low_voltage_reset_out = s_reg.lowv_reset;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  a_reset_mode: assert property ($rose(rst_b_in)
    |-> link.mode == RBK_MODE_A)
    else $error("backup mode not standard after reset");
  a_mode_write: assert property (wr_in && (addr_in == `RBK_OFF_BACKUP)
    |=> link.mode == rbk_mode_t'($past(wdata_in[1:0])))
    else $error("mode bits not decoded");
  a_bus_lowv: assert property (!vdd_ok_reset_in
    |-> ##2 !bus_enable_out)
    else $error("bus left on below reset");
  a_alarm_gate: assert property ($rose(s_reg.status[0])
    |-> $past(s_reg.alarm0_enable))
    else $error("alarm flag with alarm disabled");
  a_alarm_sets: assert property (link.match && s_reg.alarm0_enable
    && !s_reg.repeat_mode |=> s_reg.status[0] && irq_pin_oe_out)
    else $error("alarm match lost");
  a_single_hold: assert property (!s_reg.repeat_mode && s_reg.status[0]
    |-> irq_pin_oe_out)
    else $error("single alarm not held");
  a_pulse_train: assert property (s_reg.repeat_mode && ev[0]
    |=> (irq_pin_oe_out || !s_reg.repeat_mode)[*8])
    else $error("repeat pulse too short");
  a_set_wins: assert property (rd_status && ev[0]
    |=> s_reg.status[0])
    else $error("event lost on status read");
  c_single: cover property (!s_reg.repeat_mode && $rose(irq_pin_oe_out));
  c_repeat: cover property (s_reg.repeat_mode && ev[0]);
  c_sec30: cover property (link.match && (s_reg.alarm[0] == 8'hb0)
    && s_reg.repeat_mode);
  c_battery: cover property ($rose(on_battery_out) && bus_enable_out);
endmodule
`default_nettype wire
